// ==== common/pim_pkg.sv ====
package pim_pkg;

  // ----------------------------------------------------------------
  // event numbering
  // ----------------------------------------------------------------
  localparam int unsigned NUM_EVT = 24;
  localparam int unsigned EV_CONV_DONE = 0; // conv_done_evt
  localparam int unsigned EV_PEN_TOUCH = 1; // pen_touch_evt
  localparam int unsigned EV_WEAK_BUS = 2; // weak_bus_supply_evt
  localparam int unsigned EV_WEAK_AUX = 3; // weak_aux_supply_evt
  localparam int unsigned EV_BUS_OVERVOLT = 4; // bus_overvolt_evt
  localparam int unsigned EV_CHARGE_DONE = 5; // charge_done_evt
  localparam int unsigned EV_CHARGE_TIMEOUT = 6; // charge_timeout_evt
  localparam int unsigned EV_BATT_TEMP = 7; // batt_temp_evt
  localparam int unsigned EV_BATT_REMOVED = 8; // batt_removed_evt
  localparam int unsigned EV_SHORT_CIRCUIT = 9; // short_circuit_evt
  localparam int unsigned EV_BUTTON_A = 10; // button_a_evt
  localparam int unsigned EV_BUTTON_B = 11; // button_b_evt
  localparam int unsigned EV_DIE_HOT_FIRST = 12; // die_hot_level1..4_evt
  localparam int unsigned EV_SLOWCLK_SWITCH = 16; // slowclk_switch_evt
  localparam int unsigned EV_SECOND_TICK = 17; // second_tick_evt
  localparam int unsigned EV_ALARM_MATCH = 18; // alarm_match_evt
  localparam int unsigned EV_TIMEKEEPER_LOST = 19; // timekeeper_lost_evt
  localparam int unsigned EV_GP_FIRST = 20; // gp_input_evt 0..3
  localparam int unsigned NUM_GP = 4;

  // ----------------------------------------------------------------
  // register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_SENSE = 8'h08;
  localparam logic [7:0] ADDR_CONFIG = 8'h0C;
  localparam logic [23:0] STATUS_RST = 24'h000000;
  localparam logic [23:0] MASK_RST = 24'hFFFFFF;
  localparam logic [21:0] CONFIG_RST = 22'h000000;

  // config field positions
  localparam int unsigned CF_OVERVOLT_DB = 0; // overvolt_debounce_sel [1:0]
  localparam int unsigned CF_BATT_DB = 2; // batt_detect_debounce_sel [3:2]
  localparam int unsigned CF_BUTTON_FALL_DB = 4; // button_fall_debounce_sel [5:4]
  localparam int unsigned CF_GP_EDGE = 6; // 2 bits per input: bit0 rise, bit1 fall
  localparam int unsigned CF_GP_DB = 14; // 2 bits per input
  localparam int unsigned CONFIG_W = 22;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // debounce times, microseconds, counted in timebase ticks
  // ----------------------------------------------------------------
  localparam int unsigned TIMEBASE_HZ = 32768;
  localparam int unsigned PEN_DB_US = 1000;
  localparam int unsigned SHORT_DB_MIN_US = 4000;
  localparam int unsigned SHORT_DB_MAX_US = 8000;
  localparam int unsigned BUTTON_DB_US = 30000;
  localparam int unsigned DIE_HOT_DB_US = 30000;
  localparam int unsigned SEL_DB_US [4] = '{0, 1000, 10000, 30000};
  localparam int unsigned BUTTON_EXT_US [4] = '{0, 10000, 20000, 30000};

  // least time, so round up to whole ticks
  function automatic int unsigned pim_us_to_ticks(input int unsigned us);
    longint unsigned prod;
    prod = longint'(us) * longint'(TIMEBASE_HZ) + 64'd999999;
    return int'(prod / 64'd1000000);
  endfunction

  localparam int unsigned PEN_DB_TICKS = pim_us_to_ticks(PEN_DB_US);
  localparam int unsigned SHORT_DB_TICKS = pim_us_to_ticks(SHORT_DB_MIN_US);
  localparam int unsigned BUTTON_DB_TICKS = pim_us_to_ticks(BUTTON_DB_US);
  localparam int unsigned DIE_HOT_DB_TICKS = pim_us_to_ticks(DIE_HOT_DB_US);
  localparam int unsigned MAX_DB_TICKS = pim_us_to_ticks(BUTTON_DB_US + 30000);

endpackage : pim_pkg

// ==== src/pim_debounce.sv ====
// one event source: qualifies a level change for a whole debounce period
module pim_debounce
  import pim_pkg::*;
#(
  parameter int unsigned CNT_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic tick,
  input wire logic din,
  input wire logic rise_en,
  input wire logic fall_en,
  input wire logic [CNT_W-1:0] rise_ticks,
  input wire logic [CNT_W-1:0] fall_ticks,
  output logic evt
);

  logic stable;
  logic [1:0] warm;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] need;

  // the period depends on the direction the input is heading
  assign need = din ? rise_ticks : fall_ticks;

  // ----------------------------------------------------------------
  // qualification
  // ----------------------------------------------------------------
  // the two synchroniser flops ahead still show their reset zero, so the
  // level is adopted on the third cycle, without an event: a source
  // already high at power-up fires no false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stable <= 1'b0;
      warm <= '0;
      cnt <= '0;
      evt <= 1'b0;
    end else if (ce) begin
      evt <= 1'b0;
      if (warm != 2'h3) begin
        warm <= warm + 2'h1;
        stable <= din;
      end else if (din == stable) begin
        cnt <= '0;
      end else if (cnt >= need) begin
        stable <= din;
        cnt <= '0;
        evt <= din ? rise_en : fall_en;
      end else if (tick) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule // pim_debounce

// ==== src/pim_top.sv ====
module pim_top
  import pim_pkg::*;
#(
  parameter int unsigned CNT_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // event sources and timebase, from outside the clock domain
  input wire logic [NUM_EVT-1:0] evt_src,
  input wire logic timebase_32k,
  // high while the power sequencer is in watchdog or on state
  input wire logic irq_allowed,
  output logic irq,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (CNT_W < 4 || (64'd1 << CNT_W) <= 64'(MAX_DB_TICKS)) begin : g_bad_cnt_w
    $error("CNT_W too narrow for the longest debounce period");
  end

  // every status bit and config field must fit one register word
  if (NUM_EVT > 32 || CONFIG_W > 32) begin : g_bad_map
    $error("status or config wider than one register word");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [NUM_EVT-1:0] src_meta;
  logic [NUM_EVT-1:0] src_sync;
  logic tb_meta;
  logic tb_sync;
  logic tb_prev;
  logic tb_tick;

  // two flops on every pin; only the second stage is read onward
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_meta <= '0;
      src_sync <= '0;
      tb_meta <= 1'b0;
      tb_sync <= 1'b0;
      tb_prev <= 1'b0;
    end else if (ce) begin
      src_meta <= evt_src;
      src_sync <= src_meta;
      tb_meta <= timebase_32k;
      tb_sync <= tb_meta;
      tb_prev <= tb_sync;
    end
  end

  // one tick per timebase period, taken on its rising edge
  // tb_prev is a third stage; only it and the second flop feed logic
  assign tb_tick = tb_sync & ~tb_prev;

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  logic [CONFIG_W-1:0] config_reg;
  logic [1:0] overvolt_debounce_sel;
  logic [1:0] batt_detect_debounce_sel;
  logic [1:0] button_fall_debounce_sel;

  // fixed-position fields, battery and button ones read by more than one source, are named once here
  assign overvolt_debounce_sel = config_reg[CF_OVERVOLT_DB +: 2];
  assign batt_detect_debounce_sel = config_reg[CF_BATT_DB +: 2];
  assign button_fall_debounce_sel = config_reg[CF_BUTTON_FALL_DB +: 2];

  // ----------------------------------------------------------------
  // per-source edge and debounce selection
  // ----------------------------------------------------------------
  logic [NUM_EVT-1:0] rise_en;
  logic [NUM_EVT-1:0] fall_en;
  logic [CNT_W-1:0] rise_ticks [NUM_EVT];
  logic [CNT_W-1:0] fall_ticks [NUM_EVT];

  function automatic logic [CNT_W-1:0] sel_ticks(input logic [1:0] sel);
    return CNT_W'(pim_us_to_ticks(SEL_DB_US[sel]));
  endfunction

  always_comb begin
    // default: rising edge, no debounce (internal completion events)
    for (int i = 0; i < NUM_EVT; i++) begin
      rise_en[i] = 1'b1;
      fall_en[i] = 1'b0;
      rise_ticks[i] = '0;
      fall_ticks[i] = '0;
    end
    // pen touch, both edges, fixed period
    fall_en[EV_PEN_TOUCH] = 1'b1;
    rise_ticks[EV_PEN_TOUCH] = CNT_W'(PEN_DB_TICKS);
    fall_ticks[EV_PEN_TOUCH] = CNT_W'(PEN_DB_TICKS);
    // weak supply detects fire on the falling side only
    rise_en[EV_WEAK_BUS] = 1'b0;
    fall_en[EV_WEAK_BUS] = 1'b1;
    rise_en[EV_WEAK_AUX] = 1'b0;
    fall_en[EV_WEAK_AUX] = 1'b1;
    // over-voltage, period chosen by software
    fall_en[EV_BUS_OVERVOLT] = 1'b1;
    rise_ticks[EV_BUS_OVERVOLT] = sel_ticks(overvolt_debounce_sel);
    fall_ticks[EV_BUS_OVERVOLT] = sel_ticks(overvolt_debounce_sel);
    // battery temperature and removal share the battery setting
    fall_en[EV_BATT_TEMP] = 1'b1;
    rise_ticks[EV_BATT_TEMP] = sel_ticks(batt_detect_debounce_sel);
    fall_ticks[EV_BATT_TEMP] = sel_ticks(batt_detect_debounce_sel);
    fall_en[EV_BATT_REMOVED] = 1'b1;
    rise_ticks[EV_BATT_REMOVED] = sel_ticks(batt_detect_debounce_sel);
    fall_ticks[EV_BATT_REMOVED] = sel_ticks(batt_detect_debounce_sel);
    // short circuit: the least time lands inside the allowed window
    rise_ticks[EV_SHORT_CIRCUIT] = CNT_W'(SHORT_DB_TICKS);
    // buttons: the falling edge may be stretched
    for (int b = EV_BUTTON_A; b <= EV_BUTTON_B; b++) begin
      fall_en[b] = 1'b1;
      rise_ticks[b] = CNT_W'(BUTTON_DB_TICKS);
      fall_ticks[b] = CNT_W'(pim_us_to_ticks(BUTTON_DB_US + BUTTON_EXT_US[button_fall_debounce_sel]));
    end
    // die temperature thresholds
    for (int t = EV_DIE_HOT_FIRST; t < EV_DIE_HOT_FIRST + 4; t++) begin
      fall_en[t] = 1'b1;
      rise_ticks[t] = CNT_W'(DIE_HOT_DB_TICKS);
      fall_ticks[t] = CNT_W'(DIE_HOT_DB_TICKS);
    end
    // slow clock source change, both edges, immediate
    fall_en[EV_SLOWCLK_SWITCH] = 1'b1;
    // general inputs, edge and period both from software
    for (int g = 0; g < NUM_GP; g++) begin
      rise_en[EV_GP_FIRST + g] = config_reg[CF_GP_EDGE + 2*g];
      fall_en[EV_GP_FIRST + g] = config_reg[CF_GP_EDGE + 2*g + 1];
      rise_ticks[EV_GP_FIRST + g] = sel_ticks(config_reg[CF_GP_DB + 2*g +: 2]);
      fall_ticks[EV_GP_FIRST + g] = sel_ticks(config_reg[CF_GP_DB + 2*g +: 2]);
    end
  end

  // ----------------------------------------------------------------
  // debouncers
  // ----------------------------------------------------------------
  logic [NUM_EVT-1:0] evt_set;

  // one qualifier per source; fixed and selected periods alike
  for (genvar i = 0; i < NUM_EVT; i++) begin : g_db
    pim_debounce #(
      .CNT_W(CNT_W)
    ) u_db (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .tick(tb_tick),
      .din(src_sync[i]),
      .rise_en(rise_en[i]),
      .fall_en(fall_en[i]),
      .rise_ticks(rise_ticks[i]),
      .fall_ticks(fall_ticks[i]),
      .evt(evt_set[i])
    );
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic [31:0] wr_bits;
  logic [31:0] wr_be;
  logic unused_wr_hi;

  // both halves held and no response pending: commit this cycle
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  // byte lanes the strobes enable; disabled lanes keep their old bits
  assign wr_be = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_bits = wr_data & wr_be;
  // the top lane, bits 31:24, has no register bits behind it
  assign unused_wr_hi = ^{wr_be[31:NUM_EVT], wr_bits[31:NUM_EVT]};

  // address and data taken in either order, each held until response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      // unmapped address: error answer, nothing written
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        unique case (wr_addr)
          ADDR_STATUS, ADDR_MASK, ADDR_SENSE, ADDR_CONFIG: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // status, mask, config and interrupt line
  // ----------------------------------------------------------------
  logic [NUM_EVT-1:0] status;
  logic [NUM_EVT-1:0] mask;
  logic [NUM_EVT-1:0] clr_bits;
  logic [NUM_EVT-1:0] next_status;
  logic [NUM_EVT-1:0] next_mask;

  assign clr_bits = (wr_fire && wr_addr == ADDR_STATUS) ? wr_bits[NUM_EVT-1:0] : '0;
  // set wins over clear, so an event during a clear is never lost
  assign next_status = (status & ~clr_bits) | evt_set;
  // mask follows the written bits in enabled lanes, zeros unmask
  assign next_mask = (wr_fire && wr_addr == ADDR_MASK)
                     ? ((mask & ~wr_be[NUM_EVT-1:0]) | wr_bits[NUM_EVT-1:0])
                     : mask;

  // status moves every cycle; mask and config only on a committed write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= STATUS_RST;
      mask <= MASK_RST;
      config_reg <= CONFIG_RST;
    end else if (ce) begin
      status <= next_status;
      mask <= next_mask;
      if (wr_fire && wr_addr == ADDR_CONFIG) begin
        config_reg <= (config_reg & ~wr_be[CONFIG_W-1:0]) | wr_bits[CONFIG_W-1:0];
      end
    end
  end

  // latched and unmasked, as they will stand after this edge
  logic [NUM_EVT-1:0] pending;
  assign pending = next_status & ~next_mask;

  // computed from next values so the line tracks status and mask in the
  // same edge: no one-cycle dip when a clear meets a new event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= irq_allowed && |pending;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  // answered one edge after the take; arready stays low until handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      // sense is the synchronised pin level itself: never latched or cleared
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          ADDR_STATUS: s_axi_rdata <= 32'(status);
          ADDR_MASK: s_axi_rdata <= 32'(mask);
          ADDR_SENSE: s_axi_rdata <= 32'(src_sync);
          ADDR_CONFIG: s_axi_rdata <= 32'(config_reg);
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // protection bits carry no meaning for this block
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule // pim_top

// ==== tb/pim_cpu_model.sv ====
// processor side: axi4-lite master, one write and one read at a time
module pim_cpu_model
  import pim_pkg::*;
(
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  int lag = 0; // extra cycles before taking an answer, for a slow cpu

  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
  end

  // clearing and unmasking are plain writes of ones and zeros
  task automatic wr(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    // released payload must not keep looking valid
    s_axi_awaddr <= ~addr;
    s_axi_wdata <= ~data;
    repeat (lag) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~addr;
    repeat (lag) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // pim_cpu_model

// ==== tb/pim_top_monitor.sv ====
module pim_top_monitor
  import pim_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_allowed,
  input wire logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // set once software has addressed the mask; all sources start masked
  logic mask_seen;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_seen <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == ADDR_MASK) begin
      mask_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt line
  // ----------------------------------------------------------------
  irq_gate_a: assert property (!irq_allowed |=> !irq)
    else $error("irq high outside allowed power state");
  mask_first_a: assert property (irq |-> mask_seen)
    else $error("irq high before any mask write");
  irq_hold_a: assert property (irq && irq_allowed && s_axi_awready |=> irq)
    else $error("irq dropped with no write committing");
  irq_drop_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid) || !$past(irq_allowed))
    else $error("irq fell without a committed write");

  // ----------------------------------------------------------------
  // register bus answers
  // ----------------------------------------------------------------
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two edges after take");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one edge after take");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response moved before taken");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved before taken");

  irq_rise_c: cover property ($rose(irq));
  irq_fall_c: cover property ($fell(irq));
  slverr_c: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
endmodule // pim_top_monitor

bind pim_top pim_top_monitor u_monitor (
  .aclk, .aresetn, .irq_allowed, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

// ==== tb/tb_pim_top.sv ====
module tb_pim_top
  import pim_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic irq_allowed = 1'b1;
  logic [NUM_EVT-1:0] evt_src = '0;
  logic [1:0] tb_div = 2'h0;
  logic irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int bad_count = 0;
  int n_tests = 0;

  // timebase sped up to one tick per 4 clocks so debounce runs stay short
  always @(posedge aclk) tb_div <= tb_div + 2'h1;

  pim_top #(.CNT_W(12)) DUT (
    .aclk, .aresetn, .ce(1'b1), .evt_src, .timebase_32k(tb_div[1]), .irq_allowed, .irq,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  pim_cpu_model cpu (
    .aclk, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  // ----------------------------------------------------------------
  // compare and bus helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    cpu.rd(a, rdat, resp);
    check(rdat, exp);
    check({30'h0, resp}, {30'h0, er});
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(ADDR_MASK, 32'h00FFFFFF, RESP_OKAY);
    rd_chk(ADDR_STATUS, 32'h0, RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    cpu.wr(ADDR_CONFIG, 32'hFFFFFFFF, resp);
    rd_chk(ADDR_CONFIG, 32'h003FFFFF, RESP_OKAY);
    cpu.wr(8'h10, 32'h1, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    rd_chk(8'h10, 32'h0, RESP_SLVERR);
  endtask

  // masked latch, poll, unmask, clear, clear racing a new event, power gate
  task automatic t_mask();
    evt_src[EV_CONV_DONE] <= 1'b1;
    repeat (10) @(posedge aclk);
    evt_src[EV_CONV_DONE] <= 1'b0;
    repeat (10) @(posedge aclk);
    rd_chk(ADDR_STATUS, 32'h1, RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    cpu.wr(ADDR_MASK, 32'h00FFFFDE, resp);
    check({31'h0, irq}, 32'h1);
    evt_src[EV_CHARGE_DONE] <= 1'b1;
    // the clear commits at the very edge at which the new event latches
    repeat (1) @(posedge aclk);
    fork
      cpu.wr(ADDR_STATUS, 32'h1, resp);
      repeat (4) begin
        @(posedge aclk);
        check({31'h0, irq}, 32'h1);
      end
    join
    check({31'h0, irq}, 32'h1);
    rd_chk(ADDR_STATUS, 32'h20, RESP_OKAY);
    irq_allowed <= 1'b0;
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    irq_allowed <= 1'b1;
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    cpu.wr(ADDR_STATUS, 32'h20, resp);
    check({31'h0, irq}, 32'h0);
    evt_src[EV_CHARGE_DONE] <= 1'b0;
  endtask

  // falling-edge supply event, live sense, writes to sense ignored; slow cpu
  task automatic t_weak();
    cpu.lag = 2;
    evt_src[EV_WEAK_BUS] <= 1'b1;
    repeat (10) @(posedge aclk);
    rd_chk(ADDR_SENSE, 32'h4, RESP_OKAY);
    cpu.wr(ADDR_SENSE, 32'h0, resp);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    rd_chk(ADDR_STATUS, 32'h0, RESP_OKAY);
    evt_src[EV_WEAK_BUS] <= 1'b0;
    repeat (10) @(posedge aclk);
    rd_chk(ADDR_SENSE, 32'h0, RESP_OKAY);
    rd_chk(ADDR_STATUS, 32'h4, RESP_OKAY);
    cpu.wr(ADDR_STATUS, 32'h4, resp);
    cpu.lag = 0;
  endtask

  // general input 0: rising edge only, no debounce; zeros clear config
  task automatic t_gp();
    cpu.wr(ADDR_CONFIG, 32'h40, resp);
    rd_chk(ADDR_CONFIG, 32'h40, RESP_OKAY);
    evt_src[EV_GP_FIRST] <= 1'b1;
    repeat (10) @(posedge aclk);
    evt_src[EV_GP_FIRST] <= 1'b0;
    repeat (10) @(posedge aclk);
    rd_chk(ADDR_STATUS, 32'h00100000, RESP_OKAY);
    cpu.wr(ADDR_STATUS, 32'h00100000, resp);
  endtask

  // pen debounce of 33 ticks, 132 clocks: short pulse dropped, both edges latch
  task automatic t_pen();
    evt_src[EV_PEN_TOUCH] <= 1'b1;
    repeat (60) @(posedge aclk);
    evt_src[EV_PEN_TOUCH] <= 1'b0;
    repeat (200) @(posedge aclk);
    rd_chk(ADDR_STATUS, 32'h0, RESP_OKAY);
    evt_src[EV_PEN_TOUCH] <= 1'b1;
    repeat (100) @(posedge aclk);
    rd_chk(ADDR_STATUS, 32'h0, RESP_OKAY);
    repeat (100) @(posedge aclk);
    rd_chk(ADDR_STATUS, 32'h2, RESP_OKAY);
    cpu.wr(ADDR_STATUS, 32'h2, resp);
    evt_src[EV_PEN_TOUCH] <= 1'b0;
    repeat (200) @(posedge aclk);
    rd_chk(ADDR_STATUS, 32'h2, RESP_OKAY);
  endtask

  initial begin
    forever #50 aclk = ~aclk;
  end

  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_mask();
    t_weak();
    t_gp();
    t_pen();
    stop_test();
  end

  // watchdog: the whole run needs under 3000 clocks
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    stop_test();
  end
endmodule // tb_pim_top
